// *** hw/perf_stat_pkg.sv ***
// constants for the counter 4/5 event-select block: register map, field layout, event encodings
//
// Notes on behaviour
// RULE1: counter 4 event type field, bits 13-15
// RULE2: retried packets and words never count
// RULE3: type 000 counts unicast request packets only
// RULE4: type 001 counts every unicast packet
// RULE5: 010 retry symbols; 011 other symbols
// RULE6: type 100 counts unicast 32-bit words
// RULE7: 101 multicast packets; 110 multicast symbols
// RULE8: type 111 counts multicast 32-bit words
// RULE9: counter 5 priority enables, bits 16-19
// RULE10: all priority enables zero disables counter
// RULE11: symbols count when any priority enabled
// RULE12: counter 5 direction bit 23, 1=transmit
// RULE13: counter 5 type field, bits 29-31
// RULE14: counters saturate; a read clears them
// RULE15: software may write any counter value
// RULE16: counter 4 has priority and direction too
// RULE17: reserved bits read zero; reset zero
package perf_stat_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [11:0] CONTROL_OFFSET = 12'h000;
	localparam logic [11:0] STAT4_OFFSET = 12'h004;
	localparam logic [11:0] STAT5_OFFSET = 12'h008;

	////////////////////////////////////////////////////////////////////////////////
	// control field positions, index 0 is counter 4, index 1 is counter 5
	localparam int unsigned PRIO_LSB [2] = '{0, 16};
	localparam int unsigned DIR_BIT [2] = '{7, 23};
	localparam int unsigned TYPE_LSB [2] = '{13, 29};
	localparam logic [31:0] CONTROL_RW_MASK = 32'he08fe08f;
	localparam logic [31:0] CONTROL_RESET = 32'h00000000;
	localparam logic [31:0] COUNT_RESET = 32'h00000000;

	////////////////////////////////////////////////////////////////////////////////
	// event type encodings
	localparam logic [2:0] EV_UNI_REQUEST = 3'h0;
	localparam logic [2:0] EV_UNI_PACKET = 3'h1;
	localparam logic [2:0] EV_RETRY_SYMBOL = 3'h2;
	localparam logic [2:0] EV_OTHER_SYMBOL = 3'h3;
	localparam logic [2:0] EV_UNI_WORD = 3'h4;
	localparam logic [2:0] EV_MC_PACKET = 3'h5;
	localparam logic [2:0] EV_MC_SYMBOL = 3'h6;
	localparam logic [2:0] EV_MC_WORD = 3'h7;

endpackage : perf_stat_pkg

// *** hw/stat_counter.sv ***
// one saturating statistics counter with event qualification
`timescale 1ns/100ps
module stat_counter #(
	parameter int COUNT_WIDTH = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [2:0] event_sel,
	input wire logic [3:0] prio_en,
	input wire logic dir,
	input wire logic [1:0] pkt_valid,
	input wire logic [1:0] pkt_is_request,
	input wire logic [1:0] pkt_multicast,
	input wire logic [1:0] pkt_retried,
	input wire logic [3:0] pkt_prio,
	input wire logic [1:0] word_valid,
	input wire logic [1:0] word_multicast,
	input wire logic [1:0] word_retried,
	input wire logic [3:0] word_prio,
	input wire logic [1:0] sym_valid,
	input wire logic [1:0] sym_retry,
	input wire logic [1:0] sym_multicast,
	input wire logic sw_write,
	input wire logic [COUNT_WIDTH-1:0] sw_wdata,
	input wire logic read_clear,
	output logic [COUNT_WIDTH-1:0] count
);

	////////////////////////////////////////////////////////////////////////////////
	// event qualification
	logic [COUNT_WIDTH-1:0] count_reg;
	logic [COUNT_WIDTH-1:0] count_next;
	logic [COUNT_WIDTH-1:0] count_inc;
	wire logic [1:0] pkt_prio_sel = dir ? pkt_prio[3:2] : pkt_prio[1:0]; // RULE12 RULE16
	wire logic [1:0] word_prio_sel = dir ? word_prio[3:2] : word_prio[1:0];
	wire logic any_en = |prio_en; // RULE10
	wire logic pkt_ok = pkt_valid[dir] & ~pkt_retried[dir] & prio_en[pkt_prio_sel]; // RULE2 RULE9
	wire logic word_ok = word_valid[dir] & ~word_retried[dir] & prio_en[word_prio_sel]; // RULE2
	// symbols have no priority, so any enabled priority lets them through
	wire logic sym_ok = sym_valid[dir] & any_en; // RULE11
	wire logic [7:0] hit_by_type;
	wire logic event_hit;
	wire logic saturated = &count_reg;

	assign hit_by_type[0] = pkt_ok & ~pkt_multicast[dir] & pkt_is_request[dir]; // RULE3
	assign hit_by_type[1] = pkt_ok & ~pkt_multicast[dir]; // RULE4
	assign hit_by_type[2] = sym_ok & sym_retry[dir]; // RULE5
	assign hit_by_type[3] = sym_ok & ~sym_retry[dir] & ~sym_multicast[dir]; // RULE5
	assign hit_by_type[4] = word_ok & ~word_multicast[dir]; // RULE6
	assign hit_by_type[5] = pkt_ok & pkt_multicast[dir]; // RULE7
	assign hit_by_type[6] = sym_ok & sym_multicast[dir]; // RULE7
	assign hit_by_type[7] = word_ok & word_multicast[dir]; // RULE8
	assign event_hit = hit_by_type[event_sel];

	////////////////////////////////////////////////////////////////////////////////
	// counter: write beats clear, an event in the clearing cycle is kept
	assign count_inc = count_reg + 1'b1;
	assign count_next = sw_write ? sw_wdata : // RULE15
		read_clear ? {{(COUNT_WIDTH-1){1'b0}}, event_hit} : // RULE14
		(event_hit & ~saturated) ? count_inc : count_reg; // RULE14

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= COUNT_WIDTH'(perf_stat_pkg::COUNT_RESET);
		end else if (ce) begin
			count_reg <= count_next;
		end
	end

	assign count = count_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_count_saturates: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		(ce && saturated && !sw_write && !read_clear) |=> saturated)
		else $error("counter wrapped past its maximum");

	a_read_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		(ce && read_clear && !sw_write) |=> (count_reg <= COUNT_WIDTH'(1)))
		else $error("read did not clear the counter");

	a_disabled_holds: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		(prio_en == 4'h0 && !sw_write && !read_clear) |=> $stable(count_reg))
		else $error("counter moved with all priorities disabled");

	a_retry_not_counted: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		(event_sel == perf_stat_pkg::EV_UNI_REQUEST && pkt_retried[dir] && !sw_write && !read_clear)
		|=> $stable(count_reg))
		else $error("retried packet was counted");

	a_word_counts: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		(ce && event_sel == perf_stat_pkg::EV_UNI_WORD && word_valid[dir] && !word_retried[dir]
		&& !word_multicast[dir] && prio_en[word_prio_sel] && !saturated && !sw_write && !read_clear)
		|=> count_reg == $past(count_reg) + 1'b1)
		else $error("unicast word not counted");

	a_symbol_any_prio: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		(ce && event_sel == perf_stat_pkg::EV_RETRY_SYMBOL && sym_valid[dir] && sym_retry[dir]
		&& any_en && !saturated && !sw_write && !read_clear)
		|=> count_reg == $past(count_reg) + 1'b1)
		else $error("retry symbol not counted");

	a_sw_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
		(ce && sw_write) |=> count_reg == $past(sw_wdata))
		else $error("software write did not load the counter");

endmodule : stat_counter

// *** hw/port_perf_stat_event_select.sv ***
// APB register block with event selection for statistics counters 4 and 5
`timescale 1ns/100ps
module port_perf_stat_event_select #(
	parameter int ADDR_WIDTH = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] pkt_valid,
	input wire logic [1:0] pkt_is_request,
	input wire logic [1:0] pkt_multicast,
	input wire logic [1:0] pkt_retried,
	input wire logic [3:0] pkt_prio,
	input wire logic [1:0] word_valid,
	input wire logic [1:0] word_multicast,
	input wire logic [1:0] word_retried,
	input wire logic [3:0] word_prio,
	input wire logic [1:0] sym_valid,
	input wire logic [1:0] sym_retry,
	input wire logic [1:0] sym_multicast,
	output logic [31:0] stat4_count,
	output logic [31:0] stat5_count
);

	////////////////////////////////////////////////////////////////////////////////
	// apb decode: one wait state, answer registered
	logic [31:0] control_reg;
	logic [31:0] control_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] counts [2];
	logic [31:0] strb_mask;

	wire logic access = psel & penable;
	// data is captured on the first access edge, the write lands on the completing edge
	wire logic capture = access & ~pready_reg;
	wire logic complete = access & pready_reg;
	wire logic aligned = (paddr[1:0] == 2'b00);
	wire logic control_hit = aligned && (paddr == ADDR_WIDTH'(perf_stat_pkg::CONTROL_OFFSET));
	wire logic stat4_hit = aligned && (paddr == ADDR_WIDTH'(perf_stat_pkg::STAT4_OFFSET));
	wire logic stat5_hit = aligned && (paddr == ADDR_WIDTH'(perf_stat_pkg::STAT5_OFFSET));
	wire logic addr_hit = control_hit | stat4_hit | stat5_hit;
	wire logic [1:0] stat_hit = {stat5_hit, stat4_hit};
	wire logic write_done = complete & pwrite;
	// clearing on the capture edge means an event there is neither read nor lost
	wire logic read_take = capture & ~pwrite;

	////////////////////////////////////////////////////////////////////////////////
	// byte lanes
	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign strb_mask[b*8 +: 8] = {8{pstrb[b]}};
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register
	assign control_next = ((control_reg & ~strb_mask) | (pwdata & strb_mask))
		& perf_stat_pkg::CONTROL_RW_MASK; // RULE17

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= perf_stat_pkg::CONTROL_RESET; // RULE17
		end else if (ce && write_done && control_hit) begin
			control_reg <= control_next; // RULE1 RULE9 RULE12 RULE13 RULE16
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// counters 4 and 5
	for (genvar c = 0; c < 2; c++) begin : g_stat
		wire logic [3:0] prio_field = control_reg[perf_stat_pkg::PRIO_LSB[c] +: 4];
		// lowest field bit enables priority 3
		wire logic [3:0] prio_en = {prio_field[0], prio_field[1], prio_field[2], prio_field[3]}; // RULE9 RULE16
		wire logic [2:0] event_sel = control_reg[perf_stat_pkg::TYPE_LSB[c] +: 3]; // RULE1 RULE13
		wire logic dir = control_reg[perf_stat_pkg::DIR_BIT[c]]; // RULE12 RULE16
		wire logic [31:0] sw_wdata = (counts[c] & ~strb_mask) | (pwdata & strb_mask);
		wire logic sw_write = write_done & stat_hit[c]; // RULE15
		wire logic read_clear = read_take & stat_hit[c]; // RULE14

		stat_counter #(
			.COUNT_WIDTH(32)
		) u_counter (
			.pclk(pclk),
			.presetn(presetn),
			.ce(ce),
			.event_sel(event_sel),
			.prio_en(prio_en),
			.dir(dir),
			.pkt_valid(pkt_valid),
			.pkt_is_request(pkt_is_request),
			.pkt_multicast(pkt_multicast),
			.pkt_retried(pkt_retried),
			.pkt_prio(pkt_prio),
			.word_valid(word_valid),
			.word_multicast(word_multicast),
			.word_retried(word_retried),
			.word_prio(word_prio),
			.sym_valid(sym_valid),
			.sym_retry(sym_retry),
			.sym_multicast(sym_multicast),
			.sw_write(sw_write),
			.sw_wdata(sw_wdata),
			.read_clear(read_clear),
			.count(counts[c])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// read answer
	assign prdata_next = !capture ? 32'h00000000 :
		control_hit ? control_reg :
		stat4_hit ? counts[0] :
		stat5_hit ? counts[1] : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else if (ce) begin
			pready_reg <= capture;
			pslverr_reg <= capture & ~addr_hit;
			prdata_reg <= prdata_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign stat4_count = counts[0];
	assign stat5_count = counts[1];

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
		(control_reg & ~perf_stat_pkg::CONTROL_RW_MASK) == 32'h00000000)
		else $error("reserved control bit is set");

	a_control_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		(ce && write_done && control_hit && pstrb == 4'hf)
		|=> control_reg == ($past(pwdata) & perf_stat_pkg::CONTROL_RW_MASK))
		else $error("control write did not land");

	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && capture) |=> pready_reg ##1 !pready_reg || !ce)
		else $error("apb answer not one cycle after access");

	a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && capture && !addr_hit && !pwrite) |=> (pslverr_reg && prdata_reg == 32'h00000000))
		else $error("unmapped read not flagged");

endmodule : port_perf_stat_event_select

// *** testbench/link_partner.sv ***
// link partner model: sends packets, data words and control symbols
`timescale 1ns/100ps
module link_partner (
	input wire logic pclk,
	output logic [1:0] pkt_valid,
	output logic [1:0] pkt_is_request,
	output logic [1:0] pkt_multicast,
	output logic [1:0] pkt_retried,
	output logic [3:0] pkt_prio,
	output logic [1:0] word_valid,
	output logic [1:0] word_multicast,
	output logic [1:0] word_retried,
	output logic [3:0] word_prio,
	output logic [1:0] sym_valid,
	output logic [1:0] sym_retry,
	output logic [1:0] sym_multicast
);
	initial begin
		{pkt_valid, pkt_is_request, pkt_multicast, pkt_retried, pkt_prio} = '0;
		{word_valid, word_multicast, word_retried, word_prio, sym_valid, sym_retry, sym_multicast} = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// qualifiers flip after each pulse so a stale value is never mistaken for a live one
	task automatic pkt(input int s, input logic rq, input logic mc, input logic rt, input logic [1:0] pr);
		@(posedge pclk);
		pkt_valid[s] <= 1'b1;
		{pkt_is_request[s], pkt_multicast[s], pkt_retried[s]} <= {rq, mc, rt};
		pkt_prio[s*2 +: 2] <= pr;
		@(posedge pclk);
		pkt_valid[s] <= 1'b0;
		{pkt_is_request[s], pkt_multicast[s], pkt_retried[s]} <= ~{rq, mc, rt};
		pkt_prio[s*2 +: 2] <= ~pr;
	endtask : pkt
	task automatic word(input int s, input logic mc, input logic rt, input logic [1:0] pr);
		@(posedge pclk);
		word_valid[s] <= 1'b1;
		{word_multicast[s], word_retried[s]} <= {mc, rt};
		word_prio[s*2 +: 2] <= pr;
		@(posedge pclk);
		word_valid[s] <= 1'b0;
		{word_multicast[s], word_retried[s]} <= ~{mc, rt};
		word_prio[s*2 +: 2] <= ~pr;
	endtask : word
	task automatic sym(input int s, input logic rt, input logic mc);
		@(posedge pclk);
		sym_valid[s] <= 1'b1;
		{sym_retry[s], sym_multicast[s]} <= {rt, mc};
		@(posedge pclk);
		sym_valid[s] <= 1'b0;
		{sym_retry[s], sym_multicast[s]} <= ~{rt, mc};
	endtask : sym
endmodule : link_partner

// *** testbench/test_port_perf_stat_event_select.sv ***
// self-checking bench for the counter 4/5 event-select block
`timescale 1ns/100ps
module test_port_perf_stat_event_select;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic ce = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, stat4_count, stat5_count, rd;
	logic [3:0] pstrb = 4'hf, pkt_prio, word_prio;
	logic [1:0] pkt_valid, pkt_is_request, pkt_multicast, pkt_retried, word_valid, word_multicast;
	logic [1:0] word_retried, sym_valid, sym_retry, sym_multicast;
	logic er;
	int failures = 0, cmp_count = 0;
	always #25 pclk = ~pclk;
	port_perf_stat_event_select port_perf_stat_event_select_i (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid),
		.pkt_is_request(pkt_is_request), .pkt_multicast(pkt_multicast), .pkt_retried(pkt_retried),
		.pkt_prio(pkt_prio), .word_valid(word_valid), .word_multicast(word_multicast),
		.word_retried(word_retried), .word_prio(word_prio), .sym_valid(sym_valid), .sym_retry(sym_retry),
		.sym_multicast(sym_multicast), .stat4_count(stat4_count), .stat5_count(stat5_count));
	link_partner link_partner_i (.pclk(pclk), .pkt_valid(pkt_valid), .pkt_is_request(pkt_is_request),
		.pkt_multicast(pkt_multicast), .pkt_retried(pkt_retried), .pkt_prio(pkt_prio),
		.word_valid(word_valid), .word_multicast(word_multicast), .word_retried(word_retried),
		.word_prio(word_prio), .sym_valid(sym_valid), .sym_retry(sym_retry), .sym_multicast(sym_multicast));
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) chk("pready", 32'h1, 32'h0);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	// one control word: same type, priority field and direction for both counters
	function automatic logic [31:0] ctl(input logic [2:0] t, input logic [3:0] p, input logic d);
		return {t, 5'h00, d, 3'h0, p, t, 5'h00, d, 3'h0, p};
	endfunction : ctl
	task automatic rd_both(input logic [31:0] e4, input logic [31:0] e5);
		apb(1'b0, perf_stat_pkg::STAT4_OFFSET, 32'h0);
		chk("stat4", e4, rd);
		apb(1'b0, perf_stat_pkg::STAT5_OFFSET, 32'h0);
		chk("stat5", e5, rd);
	endtask : rd_both
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_regs;
		apb(1'b0, perf_stat_pkg::CONTROL_OFFSET, 32'h0);
		chk("control reset", perf_stat_pkg::CONTROL_RESET, rd);
		rd_both(32'h0, 32'h0);
		apb(1'b1, perf_stat_pkg::CONTROL_OFFSET, 32'hffffffff);
		apb(1'b0, perf_stat_pkg::CONTROL_OFFSET, 32'h0);
		chk("control mask", 32'he08fe08f, rd);
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		$display("test_regs done");
	endtask : test_regs
	task automatic test_types;
		logic [31:0] e;
		for (int t = 0; t < 8; t++) begin
			apb(1'b1, perf_stat_pkg::CONTROL_OFFSET, ctl(3'(t), 4'hf, 1'b0));
			link_partner_i.pkt(0, 1'b1, 1'b0, 1'b0, 2'h2);
			link_partner_i.pkt(0, 1'b0, 1'b0, 1'b0, 2'h2);
			link_partner_i.pkt(0, 1'b1, 1'b0, 1'b1, 2'h2);
			link_partner_i.pkt(0, 1'b1, 1'b1, 1'b0, 2'h2);
			link_partner_i.pkt(1, 1'b1, 1'b0, 1'b0, 2'h2);
			link_partner_i.word(0, 1'b0, 1'b0, 2'h2);
			link_partner_i.word(0, 1'b0, 1'b1, 2'h2);
			link_partner_i.word(0, 1'b1, 1'b0, 2'h2);
			link_partner_i.sym(0, 1'b1, 1'b0);
			link_partner_i.sym(0, 1'b0, 1'b0);
			link_partner_i.sym(0, 1'b0, 1'b1);
			link_partner_i.sym(1, 1'b0, 1'b0);
			e = (t == 1) ? 32'h2 : 32'h1;
			rd_both(e, e);
			rd_both(32'h0, 32'h0);
		end
		$display("test_types done");
	endtask : test_types
	task automatic test_prio_dir;
		apb(1'b1, perf_stat_pkg::CONTROL_OFFSET, 32'h20012002);
		link_partner_i.pkt(0, 1'b0, 1'b0, 1'b0, 2'h2);
		link_partner_i.pkt(0, 1'b0, 1'b0, 1'b0, 2'h3);
		rd_both(32'h1, 32'h1);
		apb(1'b1, perf_stat_pkg::CONTROL_OFFSET, ctl(3'h3, 4'h8, 1'b0));
		link_partner_i.sym(0, 1'b0, 1'b0);
		rd_both(32'h1, 32'h1);
		apb(1'b1, perf_stat_pkg::CONTROL_OFFSET, ctl(3'h1, 4'h0, 1'b0));
		link_partner_i.pkt(0, 1'b0, 1'b0, 1'b0, 2'h2);
		link_partner_i.sym(0, 1'b0, 1'b0);
		rd_both(32'h0, 32'h0);
		apb(1'b1, perf_stat_pkg::CONTROL_OFFSET, ctl(3'h1, 4'hf, 1'b1));
		link_partner_i.pkt(0, 1'b0, 1'b0, 1'b0, 2'h0);
		link_partner_i.pkt(1, 1'b0, 1'b0, 1'b0, 2'h0);
		link_partner_i.pkt(1, 1'b1, 1'b0, 1'b0, 2'h1);
		rd_both(32'h2, 32'h2);
		$display("test_prio_dir done");
	endtask : test_prio_dir
	// a packet while the clock enable is low must leave both counters untouched
	task automatic test_ce;
		apb(1'b1, perf_stat_pkg::CONTROL_OFFSET, ctl(3'h1, 4'hf, 1'b0));
		ce <= 1'b0;
		link_partner_i.pkt(0, 1'b0, 1'b0, 1'b0, 2'h1);
		@(posedge pclk);
		chk("stat4 frozen", 32'h0, stat4_count);
		chk("stat5 frozen", 32'h0, stat5_count);
		ce <= 1'b1;
		link_partner_i.pkt(0, 1'b0, 1'b0, 1'b0, 2'h1);
		@(posedge pclk);
		chk("stat4 out", 32'h1, stat4_count);
		chk("stat5 out", 32'h1, stat5_count);
		rd_both(32'h1, 32'h1);
		$display("test_ce done");
	endtask : test_ce
	task automatic test_saturate;
		apb(1'b1, perf_stat_pkg::STAT4_OFFSET, 32'h12345678);
		apb(1'b1, perf_stat_pkg::STAT5_OFFSET, 32'hffffffff);
		link_partner_i.pkt(0, 1'b0, 1'b0, 1'b0, 2'h1);
		rd_both(32'h12345679, 32'hffffffff);
		rd_both(32'h0, 32'h0);
		$display("test_saturate done");
	endtask : test_saturate
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		test_regs();
		test_types();
		test_prio_dir();
		test_ce();
		test_saturate();
		test_done();
	end
	// the whole run needs well under a thousand cycles
	initial begin
		#(4000 * 50);
		failures++;
		test_done();
	end
endmodule : test_port_perf_stat_event_select
